//--- src/pcs_pkg.sv
// constants, register map and carrier types of the companion supervisor
// assumes a 10 MHz system clock and an already decoded register port
`default_nettype none
package pcs_pkg;
  // ==========================================
  // timing
  localparam int CLK_HZ   = 10_000_000;
  localparam int HOLD_MS  = 100;
  localparam int STEP_MS  = 100;
  localparam int DEB_MS   = 10;
  localparam int CAL_HZ   = 512;
  localparam int HOLD_CYC = CLK_HZ / 1000 * HOLD_MS;
  localparam int STEP_CYC = CLK_HZ / 1000 * STEP_MS;
  localparam int DEB_CYC  = CLK_HZ / 1000 * DEB_MS;
  localparam int CAL_HALF = CLK_HZ / (2 * CAL_HZ);
  localparam int TMR_W    = 24;
  // ==========================================
  // register offsets
  localparam logic [7:0] A_CTL0  = 8'h00;
  localparam logic [7:0] A_FLAGS = 8'h09;
  localparam logic [7:0] A_WDOG  = 8'h0A;
  localparam logic [7:0] A_CFG   = 8'h0B;
  localparam logic [7:0] A_ECTL  = 8'h0C;
  localparam logic [7:0] A_C1L   = 8'h0D;
  localparam logic [7:0] A_C1H   = 8'h0E;
  localparam logic [7:0] A_C2L   = 8'h0F;
  localparam logic [7:0] A_C2H   = 8'h10;
  localparam logic [7:0] A_SN0   = 8'h11;
  localparam logic [7:0] A_SN7   = 8'h18;
  // ==========================================
  // fields
  localparam int B_WDF  = 7;
  localparam int B_LVF  = 6;
  localparam int B_WDE  = 7;
  localparam int B_LOCK = 7;
  localparam int B_POL1 = 0;
  localparam int B_POL2 = 1;
  localparam int B_CASC = 2;
  localparam int B_SNAP = 3;
  localparam int B_TRIM = 2;
  localparam logic [3:0] WD_KEY = 4'hA;
  localparam logic [4:0] TO_MAX = 5'h1F;
  localparam logic [4:0] TO_MIN = 5'h01;
  localparam logic [7:0] R_ZERO = 8'h00;
  // ==========================================
  // types
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pcs_req_s;
  typedef enum logic [1:0] {
    RS_RUN  = 2'b00,
    RS_LOWV = 2'b01,
    RS_HOLD = 2'b10
  } pcs_rst_e;
endpackage
`default_nettype wire

//--- src/pcs_tick.sv
// interval counter: done pulses after lim+1 cycles of run
// assumes clr and run are synchronous to clk
`default_nettype none
module pcs_tick #(
  parameter int W = 24
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // control
  input  wire logic         run,
  input  wire logic         clr,
  input  wire logic [W-1:0] lim,
  // result
  output logic              done
);
  logic [W-1:0] cnt;
  assign done = run & ~clr & (cnt == lim);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) cnt <= '0;
    else if (clr | done) cnt <= '0;
    else if (run) cnt <= cnt + 1'b1;
  end
endmodule
`default_nettype wire

//--- src/pcs_evcnt.sv
// one 16-bit event counter with edge select and byte loads
// assumes ev already synchronous to clk
`default_nettype none
module pcs_evcnt #(
  parameter int W = 16
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // event input
  input  wire logic         ev,
  input  wire logic         pol,
  input  wire logic         blk,
  input  wire logic         use_ext,
  input  wire logic         ext_inc,
  // byte loads
  input  wire logic         ld_lo,
  input  wire logic         ld_hi,
  input  wire logic [7:0]   wdata,
  // state
  output logic [W-1:0]      count,
  output logic              wrap
);
  logic ev_q;
  logic edge_seen;
  logic inc;
  // pol low counts rising, high counts falling
  assign edge_seen = pol ? (ev_q & ~ev) : (~ev_q & ev);
  assign inc  = ~blk & (use_ext ? ext_inc : edge_seen);
  assign wrap = inc & (&count);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) ev_q <= 1'b0;
    else ev_q <= ev;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) count <= '0;
    else if (ld_lo | ld_hi) begin
      if (ld_lo) count[7:0] <= wdata;
      if (ld_hi) count[15:8] <= wdata;
    end
    else if (inc) count <= count + 1'b1;
  end
endmodule
`default_nettype wire

//--- src/pcs_top.sv
// companion supervisor: reset supervisor, watchdog, comparator, counters, serial id
// assumes register requests decoded from the serial bus, analog levels as digital flags
// Overview of operation
// - drive reset low while supply below trip
// - keep reset low 100 ms after supply recovers
// - low supply: ignore bus, stop watchdog
// - trip point chosen by two config bits
// - timeout code counts 100 ms steps
// - watchdog drives reset only when enabled
// - watchdog restarts when reset pulse releases
// - disabled watchdog still sets fault flag
// - maximum timeout code stops watchdog counter
// - key nibble restarts watchdog, loads timeout
// - debounced external low gives 100 ms reset
// - sticky source flags cleared only by software
// - comparator drives fail output, rising hysteresis
// - trim mode outputs 512 Hz square wave
// - two 16-bit edge counters
// - per-counter edge polarity bits
// - counter bytes readable and writable
// - snapshot bit freezes all four bytes
// - counter writes block incoming counts
// - cascade makes one 32-bit counter
// - serial bytes lockable, lock is permanent
`default_nettype none
module pcs_top
  import pcs_pkg::*;
#(
  parameter int HOLD_CYCLES = HOLD_CYC,
  parameter int STEP_CYCLES = STEP_CYC,
  parameter int DEB_CYCLES  = DEB_CYC,
  parameter int CAL_CYCLES  = CAL_HALF
) (
  // clock and reset
  input  wire logic     CLOCK,
  input  wire logic     RST,
  // register port
  input  wire pcs_req_s REG_REQ,
  output logic [7:0]    REG_RDATA,
  output logic          REG_RVALID,
  // supply comparators, bit i set when below trip level i
  input  wire logic [3:0] SUPPLY_BELOW,
  // open-drain reset pin
  input  wire logic     RST_N_IN,
  output logic          RST_N_OUT,
  output logic          RST_N_OE,
  // power-fail comparator
  input  wire logic     PF_BELOW_REF,
  input  wire logic     PF_ABOVE_HYST,
  output logic          TUNE_OR_FAIL_OUT,
  // event inputs
  input  wire logic     EVENT_IN_ONE,
  input  wire logic     EVENT_IN_TWO
);
  // ==========================================
  // declarations
  pcs_rst_e         state;
  pcs_rst_e         next_state;
  logic [7:0]       ctl0;
  logic [7:0]       wd_setup;
  logic [7:0]       cfg;
  logic [7:0]       ectl;
  logic [7:0]       serial [8];
  logic [31:0]      snap;
  logic             wd_flag;
  logic             lv_flag;
  logic             hold_lv;
  logic [4:0]       wd_cnt;
  logic [4:0]       wd_lim;
  logic             pf_state;
  logic             sq;
  logic [15:0]      cnt_one;
  logic [15:0]      cnt_two;
  logic             wrap_one;
  logic             low;
  logic             bus_ok;
  logic             we;
  logic [7:0]       wd;
  logic [7:0]       ad;
  logic             wr_ctl0;
  logic             wr_flags;
  logic             wr_wdog;
  logic             wr_cfg;
  logic             wr_ectl;
  logic             wr_c1l;
  logic             wr_c1h;
  logic             wr_c2l;
  logic             wr_c2h;
  logic             sn_hit;
  logic [2:0]       sn_idx;
  logic             sn_wr;
  logic             cnt_blk;
  logic             key_wr;
  logic             wd_run;
  logic             wd_step;
  logic [4:0]       wd_cnt_nx;
  logic             expire;
  logic             hold_done;
  logic             man_done;
  logic             cal_flip;
  logic             released;
  logic             wd_restart;
  logic             trim;
  logic [4:0]       to_code;
  logic             wd_enable;
  logic             casc;
  logic             next_wd_flag;
  logic             next_lv_flag;
  logic [7:0]       rd_mux;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = (a == b);
  endfunction

  // ==========================================
  // register decode
  assign ad       = REG_REQ.addr;
  assign wd       = REG_REQ.wdata;
  assign low      = SUPPLY_BELOW[cfg[1:0]];
  // no bus access until the low-supply reset is fully over
  assign bus_ok   = ~low & (state != RS_LOWV) & ~hold_lv;
  assign we       = REG_REQ.wr & bus_ok;
  assign wr_ctl0  = we & hit(ad, A_CTL0);
  assign wr_flags = we & hit(ad, A_FLAGS);
  assign wr_wdog  = we & hit(ad, A_WDOG);
  assign wr_cfg   = we & hit(ad, A_CFG);
  assign wr_ectl  = we & hit(ad, A_ECTL);
  assign wr_c1l   = we & hit(ad, A_C1L);
  assign wr_c1h   = we & hit(ad, A_C1H);
  assign wr_c2l   = we & hit(ad, A_C2L);
  assign wr_c2h   = we & hit(ad, A_C2H);
  assign sn_hit   = (ad >= A_SN0) & (ad <= A_SN7);
  assign sn_idx   = 3'(ad - A_SN0);
  assign sn_wr    = we & sn_hit & ~cfg[B_LOCK];
  assign cnt_blk  = wr_c1l | wr_c1h | wr_c2l | wr_c2h;
  assign key_wr   = wr_flags & (wd[3:0] == WD_KEY);
  assign trim     = ctl0[B_TRIM];
  assign to_code  = wd_setup[4:0];
  assign wd_enable      = wd_setup[B_WDE];
  assign casc     = ectl[B_CASC];

  // ==========================================
  // watchdog
  assign wd_run     = (state == RS_RUN) & ~low & (to_code != TO_MAX);
  assign wd_cnt_nx  = wd_cnt + TO_MIN;
  assign expire     = wd_step & (wd_cnt_nx >= wd_lim);
  assign released   = (state == RS_HOLD) & hold_done;
  // free running: an expiry starts the next period at once
  assign wd_restart = key_wr | released | expire;

  pcs_tick #(.W(TMR_W)) u_step (
    .clk  (CLOCK),
    .rst  (RST),
    .run  (wd_run),
    .clr  (key_wr | released),
    .lim  (TMR_W'(STEP_CYCLES - 1)),
    .done (wd_step)
  );

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) wd_cnt <= '0;
    else if (wd_restart) wd_cnt <= '0;
    else if (wd_step) wd_cnt <= wd_cnt_nx;
  end

  // code zero is treated as one step
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) wd_lim <= TO_MIN;
    else if (key_wr) wd_lim <= (to_code == 5'h00) ? TO_MIN : to_code;
    else if (released) wd_lim <= (to_code == 5'h00) ? TO_MIN : to_code;
  end

  // ==========================================
  // reset sequencer
  pcs_tick #(.W(TMR_W)) u_hold (
    .clk  (CLOCK),
    .rst  (RST),
    .run  (state == RS_HOLD),
    .clr  (state != RS_HOLD),
    .lim  (TMR_W'(HOLD_CYCLES - 1)),
    .done (hold_done)
  );

  // pin reads low while held by us, so only look in run state
  pcs_tick #(.W(TMR_W)) u_deb (
    .clk  (CLOCK),
    .rst  (RST),
    .run  ((state == RS_RUN) & ~RST_N_IN),
    .clr  (RST_N_IN | (state != RS_RUN)),
    .lim  (TMR_W'(DEB_CYCLES - 1)),
    .done (man_done)
  );

  always_comb begin
    next_state = state;
    case (state)
      RS_RUN: begin
        if (man_done) next_state = RS_HOLD;
        else if (expire & wd_enable) next_state = RS_HOLD;
      end
      RS_LOWV: begin
        if (~low) next_state = RS_HOLD;
      end
      RS_HOLD: begin
        if (hold_done) next_state = RS_RUN;
      end
      default: next_state = RS_LOWV;
    endcase
    if (low) next_state = RS_LOWV;
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) state <= RS_LOWV;
    else state <= next_state;
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) hold_lv <= 1'b1;
    else if (state == RS_LOWV) hold_lv <= 1'b1;
    else if (state == RS_RUN) hold_lv <= 1'b0;
  end

  // drive low during every non-run state
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      RST_N_OE  <= 1'b1;
      RST_N_OUT <= 1'b0;
    end
    else begin
      RST_N_OE  <= (next_state != RS_RUN);
      RST_N_OUT <= 1'b0;
    end
  end

  // ==========================================
  // source flags, set wins over clear
  assign next_wd_flag = expire | (wd_flag & ~(wr_flags & ~wd[B_WDF]));
  assign next_lv_flag = ((state != RS_LOWV) & (next_state == RS_LOWV))
                      | (lv_flag & ~(wr_flags & ~wd[B_LVF]));

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      wd_flag <= 1'b0;
      lv_flag <= 1'b1;
    end
    else begin
      wd_flag <= next_wd_flag;
      lv_flag <= next_lv_flag;
    end
  end

  // ==========================================
  // configuration registers
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      ctl0     <= R_ZERO;
      wd_setup <= R_ZERO;
      cfg      <= R_ZERO;
      ectl     <= R_ZERO;
    end
    else begin
      if (wr_ctl0) ctl0 <= wd & (8'h01 << B_TRIM);
      if (wr_wdog) wd_setup <= wd & 8'h9F;
      if (wr_cfg) cfg <= {cfg[B_LOCK] | wd[B_LOCK], wd[6:0]};
      if (wr_ectl) ectl <= wd & 8'h0F;
    end
  end

  generate
    for (genvar i = 0; i < 8; i++) begin : g_sn
      always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) serial[i] <= R_ZERO;
        else if (sn_wr & (sn_idx == 3'(i))) serial[i] <= wd;
      end
    end
  endgenerate

  // ==========================================
  // event counters
  pcs_evcnt #(.W(16)) u_cnt_one (
    .clk     (CLOCK),
    .rst     (RST),
    .ev      (EVENT_IN_ONE),
    .pol     (ectl[B_POL1]),
    .blk     (cnt_blk),
    .use_ext (1'b0),
    .ext_inc (1'b0),
    .ld_lo   (wr_c1l),
    .ld_hi   (wr_c1h),
    .wdata   (wd),
    .count   (cnt_one),
    .wrap    (wrap_one)
  );

  // in cascade the second counter takes the first one's carry
  pcs_evcnt #(.W(16)) u_cnt_two (
    .clk     (CLOCK),
    .rst     (RST),
    .ev      (EVENT_IN_TWO),
    .pol     (ectl[B_POL2]),
    .blk     (cnt_blk),
    .use_ext (casc),
    .ext_inc (wrap_one),
    .ld_lo   (wr_c2l),
    .ld_hi   (wr_c2h),
    .wdata   (wd),
    .count   (cnt_two),
    .wrap    ()
  );

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) snap <= '0;
    else if (wr_ectl & wd[B_SNAP]) snap <= {cnt_two, cnt_one};
  end

  // ==========================================
  // comparator and trim output
  pcs_tick #(.W(TMR_W)) u_cal (
    .clk  (CLOCK),
    .rst  (RST),
    .run  (trim),
    .clr  (~trim),
    .lim  (TMR_W'(CAL_CYCLES - 1)),
    .done (cal_flip)
  );

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) sq <= 1'b0;
    else if (~trim) sq <= 1'b0;
    else if (cal_flip) sq <= ~sq;
  end

  // fall at the reference, rise only past the hysteresis level
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) pf_state <= 1'b1;
    else if (PF_BELOW_REF) pf_state <= 1'b0;
    else if (PF_ABOVE_HYST) pf_state <= 1'b1;
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) TUNE_OR_FAIL_OUT <= 1'b1;
    else TUNE_OR_FAIL_OUT <= trim ? sq : pf_state;
  end

  // ==========================================
  // read back, counters come from the snapshot
  assign rd_mux = hit(ad, A_CTL0)  ? ctl0 :
                  hit(ad, A_FLAGS) ? {wd_flag, lv_flag, 6'h00} :
                  hit(ad, A_WDOG)  ? wd_setup :
                  hit(ad, A_CFG)   ? cfg :
                  hit(ad, A_ECTL)  ? ectl :
                  hit(ad, A_C1L)   ? snap[7:0] :
                  hit(ad, A_C1H)   ? snap[15:8] :
                  hit(ad, A_C2L)   ? snap[23:16] :
                  hit(ad, A_C2H)   ? snap[31:24] :
                  sn_hit           ? serial[sn_idx] : R_ZERO;

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      REG_RDATA  <= R_ZERO;
      REG_RVALID <= 1'b0;
    end
    else begin
      REG_RVALID <= REG_REQ.rd & bus_ok;
      REG_RDATA  <= (REG_REQ.rd & bus_ok) ? rd_mux : R_ZERO;
    end
  end

  // ==========================================
  // assertions
  sequence s_lv_exit;
    (state == RS_LOWV) ##1 (state == RS_HOLD);
  endsequence

  sequence s_release;
    (state == RS_HOLD) && hold_done;
  endsequence

  AST_LOW_DRIVES: assert property (@(posedge CLOCK) disable iff (RST)
    low |=> RST_N_OE && (state == RS_LOWV)) else $error("low supply not driving reset");
  AST_HOLD_AFTER_LOW: assert property (@(posedge CLOCK) disable iff (RST)
    s_lv_exit |-> RST_N_OE [*8]) else $error("reset released too early");
  AST_BUS_LOCK: assert property (@(posedge CLOCK) disable iff (RST)
    (low && REG_REQ.wr && hit(ad, A_CFG)) |=> $stable(cfg)) else $error("write taken at low supply");
  AST_TRIP_SELECT: assert property (@(posedge CLOCK) disable iff (RST)
    SUPPLY_BELOW[cfg[1:0]] |=> (state == RS_LOWV)) else $error("trip level ignored");
  AST_WDE_GATE: assert property (@(posedge CLOCK) disable iff (RST)
    (expire && !wd_enable && !low && !man_done) |=> (state == RS_RUN) && wd_flag) else $error("disabled watchdog reset");
  AST_RESTART_REL: assert property (@(posedge CLOCK) disable iff (RST)
    s_release |=> (wd_cnt == 5'h00) && !RST_N_OE) else $error("no restart at release");
  AST_MAX_STOPS: assert property (@(posedge CLOCK) disable iff (RST)
    (to_code == TO_MAX) && !wd_restart |=> $stable(wd_cnt)) else $error("max code still counts");
  AST_KEY_RESTART: assert property (@(posedge CLOCK) disable iff (RST)
    key_wr |=> (wd_cnt == 5'h00) && (wd_lim == ((to_code == 5'h00) ? TO_MIN : to_code)))
    else $error("key did not restart");
  AST_MANUAL: assert property (@(posedge CLOCK) disable iff (RST)
    (man_done && !low) |=> (state == RS_HOLD) ##1 RST_N_OE) else $error("manual reset missed");
  AST_SNAPSHOT: assert property (@(posedge CLOCK) disable iff (RST)
    (wr_ectl && wd[B_SNAP]) |=> (snap == {$past(cnt_two), $past(cnt_one)})) else $error("snapshot wrong");
  AST_LOCK_STICKY: assert property (@(posedge CLOCK) disable iff (RST)
    cfg[B_LOCK] |=> cfg[B_LOCK] && $stable(serial[0])) else $error("lock cleared or bypassed");
endmodule
`default_nettype wire

//--- test/pcs_host.sv
// host-side model: drives the decoded register port and shares the reset pin
// assumes requests are launched on the falling edge of a 10 MHz clock
`default_nettype none
module pcs_host
  import pcs_pkg::*;
(
  // clock
  input  wire logic       clk,
  // register port
  output var pcs_req_s    req,
  input  wire logic [7:0] rdata,
  input  wire logic       rvalid,
  // reset pin
  input  wire logic       oe,
  input  wire logic       drv,
  output wire logic       pin
);
  logic button;

  // ==========================================
  // pin level
  // weak pull-up: pin is high unless the device or the button pulls it
  assign pin = oe ? drv : !button;

  initial begin
    req = '0;
    button = 1'b0;
  end

  // ==========================================
  // bus cycles
  // flag clears and key writes are the host's job, never automatic
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk) req <= '{1'b1, 1'b0, a, v};
    @(negedge clk) req <= '0;
  endtask

  // answer stands one cycle, so look at every falling edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    ok = 1'b0;
    d = 8'h00;
    @(negedge clk) req <= '{1'b0, 1'b1, a, 8'h00};
    for (int i = 0; i < 3; i++) begin
      @(negedge clk) req <= '0;
      if (rvalid === 1'b1 && !ok) begin
        ok = 1'b1;
        d = rdata;
      end
    end
  endtask
endmodule
`default_nettype wire

//--- test/tb_processor_companion_supervisor.sv
// self-checking bench for the companion supervisor
// assumes pcs_host as the far side and shortened timing parameters
`default_nettype none
module tb_processor_companion_supervisor
  import pcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int HOLD = 20;
  localparam int STEP = 10;
  localparam int DEB  = 4;
  localparam int CAL  = 5;
  logic       CLOCK;
  logic       RST;
  pcs_req_s   req;
  logic [7:0] rdata;
  logic       rvalid;
  logic [3:0] below;
  logic       pin;
  logic       nout;
  logic       oe;
  logic       pf_lo;
  logic       pf_hi;
  logic       tof;
  logic       ev1;
  logic       ev2;
  logic [7:0] d;
  logic       ok;
  logic [7:0] q[$];
  int         n;
  int         n1;
  int         n2;
  int         n_errors;
  int         checked;

  pcs_top #(.HOLD_CYCLES(HOLD), .STEP_CYCLES(STEP), .DEB_CYCLES(DEB), .CAL_CYCLES(CAL)) i_dut (
    .CLOCK(CLOCK), .RST(RST), .REG_REQ(req), .REG_RDATA(rdata), .REG_RVALID(rvalid),
    .SUPPLY_BELOW(below), .RST_N_IN(pin), .RST_N_OUT(nout), .RST_N_OE(oe),
    .PF_BELOW_REF(pf_lo), .PF_ABOVE_HYST(pf_hi), .TUNE_OR_FAIL_OUT(tof),
    .EVENT_IN_ONE(ev1), .EVENT_IN_TWO(ev2));
  pcs_host i_host (.clk(CLOCK), .req(req), .rdata(rdata), .rvalid(rvalid), .oe(oe), .drv(nout), .pin(pin));

  initial begin
    CLOCK = 1'b0;
    forever #50 CLOCK = ~CLOCK;
  end

  // ==========================================
  // helpers
  task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s exp %h seen %h", s, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge CLOCK);
  endtask
  // counts falling edges until the pin drive reaches v
  task automatic wait_oe(input logic v, input int lim);
    n = 0;
    while (oe !== v) begin
      cyc(1);
      n++;
      if (n > lim) begin
        chk("oe_wait", n, lim);
        complete_run();
      end
    end
  endtask
  task automatic w(input logic [7:0] a, input logic [7:0] v);
    i_host.wr(a, v);
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    i_host.rd(a, d, ok);
    chk("reg_read", {ok, d}, {1'b1, e});
  endtask
  task automatic wcnt(input logic [7:0] a, input logic [15:0] v);
    w(a, v[7:0]);
    w(8'(a + 1), v[15:8]);
  endtask
  task automatic rcnt(input logic [7:0] a, input logic [15:0] e);
    rc(a, e[7:0]);
    rc(8'(a + 1), e[15:8]);
  endtask
  // one high pulse: a rising and a falling edge
  task automatic pulse(input logic two);
    if (two) ev2 <= 1'b1;
    else ev1 <= 1'b1;
    cyc(3);
    ev1 <= 1'b0;
    ev2 <= 1'b0;
    cyc(3);
  endtask
  task automatic gap();
    d[0] = tof;
    n = 0;
    while (tof === d[0] && n < 3 * CAL) begin
      cyc(1);
      n++;
    end
  endtask

  initial begin
    repeat (100000) @(posedge CLOCK);
    chk("timeout", 0, 1);
    complete_run();
  end

  // ==========================================
  // main sequence
  initial begin
    {RST, below, pf_lo, pf_hi, ev1, ev2, n_errors, checked} = {1'b1, 4'h0, 4'h0, 64'h0};
    void'($urandom(32'h4531));
    cyc(16);
    RST <= 1'b0;
    cyc(1);
    chk("rst_oe", oe, 1'b1);
    wait_oe(1'b0, HOLD + 6);
    chk("rst_hold", n >= HOLD - 3, 1'b1);
    w(A_WDOG, 8'hFF);
    w(A_FLAGS, 8'h40);
    rc(A_FLAGS, 8'h40);
    rc(A_WDOG, 8'h9F);
    rc(8'h30, 8'h00);
    // watchdog enabled, two steps
    w(A_WDOG, 8'h82);
    w(A_FLAGS, 8'h0A);
    wait_oe(1'b1, 2 * STEP + 6);
    chk("wd_time", n >= 2 * STEP - 3, 1'b1);
    wait_oe(1'b0, HOLD + 6);
    wait_oe(1'b1, 2 * STEP + 6);
    chk("wd_again", n >= 2 * STEP - 3, 1'b1);
    wait_oe(1'b0, HOLD + 6);
    rc(A_FLAGS, 8'h80);
    w(A_WDOG, 8'h02);
    w(A_FLAGS, 8'h0A);
    cyc(3 * STEP);
    chk("wd_off", oe, 1'b0);
    rc(A_FLAGS, 8'h80);
    w(A_WDOG, 8'h82);
    repeat (4) begin
      w(A_FLAGS, 8'h0A);
      cyc(STEP);
    end
    chk("wd_kicked", oe, 1'b0);
    w(A_FLAGS, 8'h05);
    wait_oe(1'b1, 2 * STEP + 6);
    wait_oe(1'b0, HOLD + 6);
    w(A_WDOG, 8'h9F);
    w(A_FLAGS, 8'h0A);
    cyc(40 * STEP);
    chk("wd_stop", oe, 1'b0);
    rc(A_FLAGS, 8'h00);
    // low supply at every trip code
    for (int c = 0; c < 4; c++) begin
      w(A_CFG, 8'(c));
      below <= 4'hF << (c + 1);
      cyc(4);
      chk("trip_above", oe, 1'b0);
      below <= 4'hF << c;
      cyc(2);
      chk("trip_below", oe, 1'b1);
      w(A_CFG, 8'h00);
      below <= 4'h0;
      wait_oe(1'b0, HOLD + 6);
      chk("lv_hold", n >= HOLD - 2, 1'b1);
      rc(A_CFG, 8'(c));
      rc(A_FLAGS, 8'h40);
      w(A_FLAGS, 8'h00);
    end
    // too short a press is filtered, a long one resets
    i_host.button = 1'b1;
    cyc(DEB - 2);
    i_host.button = 1'b0;
    cyc(6);
    chk("glitch", oe, 1'b0);
    i_host.button = 1'b1;
    cyc(DEB + 4);
    i_host.button = 1'b0;
    chk("manual", oe, 1'b1);
    wait_oe(1'b0, HOLD + 6);
    chk("man_hold", n >= HOLD - 4, 1'b1);
    // comparator, then trim square wave
    pf_lo <= 1'b1;
    cyc(2);
    chk("pf_fall", tof, 1'b0);
    pf_lo <= 1'b0;
    cyc(3);
    chk("pf_hyst", tof, 1'b0);
    pf_hi <= 1'b1;
    cyc(2);
    chk("pf_rise", tof, 1'b1);
    pf_lo <= 1'b1;
    w(A_CTL0, 8'h04);
    gap();
    gap();
    chk("trim_half", n, CAL);
    w(A_CTL0, 8'h00);
    pf_lo <= 1'b0;
    // counters: polarity first, then presets
    w(A_ECTL, 8'h02);
    wcnt(A_C1L, 16'hFFFE);
    wcnt(A_C2L, 16'h1234);
    n1 = $urandom_range(3, 6);
    n2 = $urandom_range(1, 4);
    repeat (n1) pulse(1'b0);
    repeat (n2) pulse(1'b1);
    w(A_ECTL, 8'h0A);
    pulse(1'b0);
    rcnt(A_C1L, 16'(16'hFFFE + n1));
    rcnt(A_C2L, 16'(16'h1234 + n2));
    w(A_ECTL, 8'h04);
    wcnt(A_C1L, 16'hFFFF);
    wcnt(A_C2L, 16'h00FF);
    pulse(1'b0);
    pulse(1'b1);
    w(A_ECTL, 8'h0C);
    rcnt(A_C1L, 16'h0000);
    rcnt(A_C2L, 16'h0100);
    // serial number, locked last since it never unlocks
    for (int i = 0; i < 8; i++) begin
      q.push_back(8'($urandom));
      w(8'(A_SN0 + i), q[i]);
    end
    w(A_CFG, 8'h80);
    for (int i = 0; i < 8; i++) begin
      w(8'(A_SN0 + i), ~q[i]);
      rc(8'(A_SN0 + i), q[i]);
    end
    w(A_CFG, 8'h00);
    rc(A_CFG, 8'h80);
    complete_run();
  end
endmodule
`default_nettype wire
